// >>> uart485_pkg.sv
// Constants shared by the serial port and its receive buffer
package uart485_pkg;
  localparam logic [2:0] OFS_DATA = 3'h0;
  localparam logic [2:0] OFS_DIV_HIGH = 3'h1;
  localparam logic [2:0] OFS_INT_CODE = 3'h2;
  localparam logic [2:0] OFS_FRAME = 3'h3;
  localparam logic [2:0] OFS_LINE_OUT = 3'h4;
  localparam logic [2:0] OFS_STATUS = 3'h5;
  localparam int BIT_DLSEL = 7;
  localparam int BIT_STOP2 = 2;
  localparam int BIT_PAR_EN = 3;
  localparam int BIT_PAR_EVEN = 4;
  localparam int BIT_PAR_STICK = 5;
  localparam int BIT_BREAK = 6;
  localparam int BIT_RTS = 1;
  localparam int BIT_USER_OUT1 = 2;
  localparam int BIT_INT_GATE = 3;
  localparam int BIT_RX_READY = 0;
  localparam int BIT_OVERRUN = 1;
  localparam int BIT_PAR_ERR = 2;
  localparam int BIT_FRAME_ERR = 3;
  localparam int BIT_BREAK_SEEN = 4;
  localparam int BIT_THR_EMPTY = 5;
  localparam int BIT_TX_IDLE = 6;
  localparam logic [7:0] INT_NONE = 8'h01;
  localparam logic [7:0] INT_RX_DATA = 8'h04;
  localparam logic [2:0] LEN_BASE = 3'h5;
  localparam logic [7:0] FRAME_RESET = 8'h03;
  localparam logic [7:0] LINE_OUT_RESET = 8'h00;
  localparam logic [15:0] DIV_RESET = 16'h000c;
  localparam int OVERSAMPLE = 16;
  localparam int REF_CLK_HZ = 1843200;
  localparam int SYS_CLK_HZ = 125000000;
  localparam int FIFO_DEPTH = 4;
  localparam int DATA_W = 8;
endpackage

// >>> rx_fifo.sv
// Small valid/ready FIFO for received characters
`timescale 1ns/10ps
module rx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic push, pop;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign o_in_ready = (count != (AW + 1)'(DEPTH));
  assign o_out_valid = (count != '0);
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_comb begin
    next_wr_ptr = push ? ptr_inc(wr_ptr) : wr_ptr;
    next_rd_ptr = pop ? ptr_inc(rd_ptr) : rd_ptr;
    next_count = count + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else if (i_ce) begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_ce && push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  // Head registered each cycle so the data output comes from a flop
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_out_data <= '0;
    end else if (i_ce) begin
      o_out_data <= (count == '0 && push) ? i_in_data :
                    (pop ? ((next_count == '0 && push) ? i_in_data : mem[next_rd_ptr])
                         : (count == '0 ? o_out_data : mem[rd_ptr]));
    end
  end
endmodule

// >>> rs485_uart_port.sv
// Byte-register serial port with transceiver direction control
`timescale 1ns/10ps
module rs485_uart_port
  import uart485_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [2:0] i_addr,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  input wire logic i_dir_jumper,
  input wire logic i_rx_line,
  output logic o_tx_line,
  output logic o_tx_drive_oe_n,
  output logic o_rts,
  output logic o_irq
);
  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  logic [7:0] frame, next_frame, line_out, next_line_out;
  logic [15:0] divisor, next_divisor;
  logic [7:0] thr, next_thr;
  logic thr_full, next_thr_full;
  logic overrun, next_overrun, par_err, next_par_err;
  logic frm_err, next_frm_err, brk_seen, next_brk_seen;
  logic dlsel, rd_data, wr_data, tx_take, tx_idle;
  logic rx_push, rx_push_ready, rx_valid;
  logic [7:0] rx_char, rx_head;
  logic rx_perr, rx_ferr, rx_brk;
  logic [7:0] status;

  assign dlsel = frame[BIT_DLSEL];
  assign rd_data = i_rd && i_addr == OFS_DATA && !dlsel;
  assign wr_data = i_wr && i_addr == OFS_DATA && !dlsel;

  always_comb begin
    next_frame = frame;
    next_line_out = line_out;
    next_divisor = divisor;
    next_thr = thr;
    next_thr_full = thr_full;
    if (tx_take) begin
      next_thr_full = 1'b0;
    end
    if (i_wr) begin
      case (i_addr)
        OFS_DATA: begin
          if (dlsel) begin
            next_divisor[7:0] = i_wdata;
          end else begin
            next_thr = i_wdata;
            next_thr_full = 1'b1;
          end
        end
        OFS_DIV_HIGH: begin
          if (dlsel) begin
            next_divisor[15:8] = i_wdata;
          end
        end
        OFS_FRAME: next_frame = i_wdata;
        OFS_LINE_OUT: next_line_out = i_wdata;
        default: ;
      endcase
    end
  end

  // Error flags: a new event wins over the clear of a status read
  always_comb begin
    next_overrun = overrun;
    next_par_err = par_err;
    next_frm_err = frm_err;
    next_brk_seen = brk_seen;
    if (i_rd && i_addr == OFS_STATUS) begin
      next_overrun = 1'b0;
      next_par_err = 1'b0;
      next_frm_err = 1'b0;
      next_brk_seen = 1'b0;
    end
    if (rx_push) begin
      next_overrun = next_overrun | !rx_push_ready;
      next_par_err = next_par_err | rx_perr;
      next_frm_err = next_frm_err | rx_ferr;
      next_brk_seen = next_brk_seen | rx_brk;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      frame <= FRAME_RESET;
      line_out <= LINE_OUT_RESET;
      divisor <= DIV_RESET;
      thr <= '0;
      thr_full <= 1'b0;
      overrun <= 1'b0;
      par_err <= 1'b0;
      frm_err <= 1'b0;
      brk_seen <= 1'b0;
    end else if (i_ce) begin
      frame <= next_frame;
      line_out <= next_line_out;
      divisor <= next_divisor;
      thr <= next_thr;
      thr_full <= next_thr_full;
      overrun <= next_overrun;
      par_err <= next_par_err;
      frm_err <= next_frm_err;
      brk_seen <= next_brk_seen;
    end
  end

  always_comb begin
    status = '0;
    status[BIT_RX_READY] = rx_valid;
    status[BIT_OVERRUN] = overrun;
    status[BIT_PAR_ERR] = par_err;
    status[BIT_FRAME_ERR] = frm_err;
    status[BIT_BREAK_SEEN] = brk_seen;
    status[BIT_THR_EMPTY] = !thr_full;
    status[BIT_TX_IDLE] = !thr_full && tx_idle;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_rdata <= '0;
    end else if (i_ce && i_rd) begin
      case (i_addr)
        OFS_DATA: o_rdata <= dlsel ? divisor[7:0] : rx_head;
        OFS_DIV_HIGH: o_rdata <= dlsel ? divisor[15:8] : 8'h00;
        OFS_INT_CODE: o_rdata <= rx_valid ? INT_RX_DATA : INT_NONE;
        OFS_FRAME: o_rdata <= frame;
        OFS_LINE_OUT: o_rdata <= line_out;
        OFS_STATUS: o_rdata <= status;
        default: o_rdata <= 8'h00;
      endcase
    end
  end

  // Jumper absent keeps the driver on; bit 2 is unused here
  assign o_rts = i_dir_jumper ? line_out[BIT_RTS] : 1'b1;
  assign o_tx_drive_oe_n = !o_rts;
  assign o_irq = line_out[BIT_INT_GATE] && rx_valid;

  // ------------------------------------------------------------
  // Baud tick: reference rate emulated by fractional accumulation
  // ------------------------------------------------------------
  logic [31:0] ref_acc, next_ref_acc;
  logic ref_tick;
  logic [15:0] div_cnt, next_div_cnt;
  logic os_tick;

  always_comb begin
    next_ref_acc = ref_acc + 32'(REF_CLK_HZ);
    ref_tick = 1'b0;
    if (next_ref_acc >= 32'(SYS_CLK_HZ)) begin
      next_ref_acc = next_ref_acc - 32'(SYS_CLK_HZ);
      ref_tick = 1'b1;
    end
    next_div_cnt = div_cnt;
    os_tick = 1'b0;
    if (ref_tick) begin
      if (div_cnt + 16'h0001 >= divisor) begin
        next_div_cnt = '0;
        os_tick = 1'b1;
      end else begin
        next_div_cnt = div_cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      ref_acc <= '0;
      div_cnt <= '0;
    end else if (i_ce) begin
      ref_acc <= next_ref_acc;
      div_cnt <= next_div_cnt;
    end
  end

  function automatic logic [3:0] data_bits(input logic [7:0] f);
    data_bits = {2'b00, f[1:0]} + {1'b0, LEN_BASE};
  endfunction

  function automatic logic parity_of(input logic [7:0] d, input logic [7:0] f);
    logic p;
    p = ^(d & (8'hff >> (4'h8 - data_bits(f))));
    if (f[BIT_PAR_STICK]) begin
      parity_of = !f[BIT_PAR_EVEN];
    end else begin
      parity_of = f[BIT_PAR_EVEN] ? p : !p;
    end
  endfunction

  // ------------------------------------------------------------
  // Transmitter
  // ------------------------------------------------------------
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_e;
  tx_state_e tx_st, next_tx_st;
  logic [7:0] tx_sh, next_tx_sh;
  logic [3:0] tx_os, next_tx_os, tx_n, next_tx_n;
  logic tx_bit, next_tx_bit;
  logic [7:0] tx_word, next_tx_word;

  assign tx_idle = (tx_st == TX_IDLE);
  // Start only on a tick so the start bit lasts a full sixteen ticks
  assign tx_take = (tx_st == TX_IDLE) && thr_full && !dlsel && os_tick;

  always_comb begin
    next_tx_st = tx_st;
    next_tx_sh = tx_sh;
    next_tx_os = tx_os;
    next_tx_n = tx_n;
    next_tx_bit = tx_bit;
    next_tx_word = tx_word;
    case (tx_st)
      TX_IDLE: begin
        next_tx_bit = 1'b1;
        if (tx_take) begin
          next_tx_sh = thr;
          next_tx_word = thr;
          next_tx_st = TX_START;
          next_tx_os = '0;
          next_tx_bit = 1'b0;
        end
      end
      default: begin
        if (os_tick) begin
          next_tx_os = tx_os + 4'h1;
          if (tx_os == 4'(OVERSAMPLE - 1)) begin
            case (tx_st)
              TX_START, TX_DATA: begin
                if (tx_st == TX_START) begin
                  next_tx_n = '0;
                end else begin
                  next_tx_n = tx_n + 4'h1;
                end
                if (tx_st == TX_DATA && tx_n + 4'h1 == data_bits(frame)) begin
                  next_tx_st = frame[BIT_PAR_EN] ? TX_PAR : TX_STOP;
                  next_tx_bit = frame[BIT_PAR_EN] ? parity_of(tx_word, frame) : 1'b1;
                  next_tx_n = '0;
                end else begin
                  next_tx_st = TX_DATA;
                  next_tx_bit = tx_sh[0];
                  next_tx_sh = {1'b0, tx_sh[7:1]};
                end
              end
              TX_PAR: begin
                next_tx_st = TX_STOP;
                next_tx_bit = 1'b1;
                next_tx_n = '0;
              end
              TX_STOP: begin
                next_tx_n = tx_n + 4'h1;
                if (!frame[BIT_STOP2] || tx_n == 4'h1) begin
                  next_tx_st = TX_IDLE;
                end
              end
              default: next_tx_st = TX_IDLE;
            endcase
          end
        end
      end
    endcase
  end

  // Copy of the character kept for parity, the shifter drains
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      tx_st <= TX_IDLE;
      tx_sh <= '0;
      tx_os <= '0;
      tx_n <= '0;
      tx_bit <= 1'b1;
      tx_word <= '0;
    end else if (i_ce) begin
      tx_st <= next_tx_st;
      tx_sh <= next_tx_sh;
      tx_os <= next_tx_os;
      tx_n <= next_tx_n;
      tx_bit <= next_tx_bit;
      tx_word <= next_tx_word;
    end
  end

  assign o_tx_line = tx_bit && !frame[BIT_BREAK];

  // ------------------------------------------------------------
  // Receiver
  // ------------------------------------------------------------
  logic [2:0] rx_sync;
  logic rx_in, next_rx_in;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_e;
  rx_state_e rx_st, next_rx_st;
  logic [7:0] rx_sh, next_rx_sh;
  logic [3:0] rx_os, next_rx_os, rx_n, next_rx_n;
  logic rx_pbit, next_rx_pbit;

  always_comb begin
    next_rx_in = (rx_sync[2] == rx_sync[1]) ? rx_sync[1] : rx_in;
    next_rx_st = rx_st;
    next_rx_sh = rx_sh;
    next_rx_os = rx_os;
    next_rx_n = rx_n;
    next_rx_pbit = rx_pbit;
    rx_push = 1'b0;
    if (os_tick) begin
      next_rx_os = rx_os + 4'h1;
      case (rx_st)
        RX_IDLE: begin
          next_rx_os = '0;
          if (!rx_in) begin
            next_rx_st = RX_START;
          end
        end
        RX_START: begin
          if (rx_os == 4'(OVERSAMPLE / 2 - 1)) begin
            next_rx_os = '0;
            next_rx_n = '0;
            next_rx_sh = '0;
            next_rx_st = rx_in ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_os == 4'(OVERSAMPLE - 1)) begin
            next_rx_sh = {rx_in, rx_sh[7:1]};
            next_rx_n = rx_n + 4'h1;
            if (rx_n + 4'h1 == data_bits(frame)) begin
              next_rx_st = frame[BIT_PAR_EN] ? RX_PAR : RX_STOP;
            end
          end
        end
        RX_PAR: begin
          if (rx_os == 4'(OVERSAMPLE - 1)) begin
            next_rx_pbit = rx_in;
            next_rx_st = RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_os == 4'(OVERSAMPLE - 1)) begin
            rx_push = 1'b1;
            next_rx_st = RX_IDLE;
          end
        end
        default: next_rx_st = RX_IDLE;
      endcase
    end
  end

  assign rx_char = rx_sh >> (4'h8 - data_bits(frame));
  assign rx_perr = frame[BIT_PAR_EN] && (rx_pbit != parity_of(rx_char, frame));
  assign rx_ferr = !rx_in;
  assign rx_brk = !rx_in && rx_sh == 8'h00;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      rx_sync <= 3'h7;
      rx_in <= 1'b1;
      rx_st <= RX_IDLE;
      rx_sh <= '0;
      rx_os <= '0;
      rx_n <= '0;
      rx_pbit <= 1'b0;
    end else if (i_ce) begin
      rx_sync <= {rx_sync[1:0], i_rx_line};
      rx_in <= next_rx_in;
      rx_st <= next_rx_st;
      rx_sh <= next_rx_sh;
      rx_os <= next_rx_os;
      rx_n <= next_rx_n;
      rx_pbit <= next_rx_pbit;
    end
  end

  rx_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_in_valid(rx_push),
    .o_in_ready(rx_push_ready),
    .i_in_data(rx_char),
    .o_out_valid(rx_valid),
    .i_out_ready(rd_data && i_ce),
    .o_out_data(rx_head)
  );
endmodule

// >>> remote_station.sv
// Remote station on the party line: listens to our frames, sends its own
`timescale 1ns/10ps
module remote_station #(
  parameter real BIT_NS = 8680.56
) (
  input wire logic i_tx_line,
  input wire logic i_tx_drive_oe_n,
  input wire logic [3:0] i_len,
  output logic o_line,
  output logic [7:0] o_rx_byte,
  output logic [7:0] o_rx_count,
  output logic o_tail_bit
);
  logic bus_level;
  // Released driver leaves the biased pair at idle high
  assign bus_level = i_tx_drive_oe_n ? 1'b1 : i_tx_line;
  initial begin
    o_line = 1'b1;
    o_rx_byte = 8'h00;
    o_rx_count = 8'h00;
    o_tail_bit = 1'b1;
  end
  // -----------------------------------------------
  // Mid-bit sampling at the nominal rate, LSB first
  // -----------------------------------------------
  always begin
    @(negedge bus_level);
    #(BIT_NS * 1.5);
    o_rx_byte = 8'h00;
    for (int b = 0; b < i_len; b++) begin
      o_rx_byte[b] = bus_level;
      #(BIT_NS);
    end
    // Bit after the data: parity when enabled, else the stop bit
    o_tail_bit = bus_level;
    o_rx_count = o_rx_count + 8'h01;
  end
  task automatic send_char(input logic [7:0] d, input int len);
    o_line = 1'b0;
    #(BIT_NS);
    for (int b = 0; b < len; b++) begin
      o_line = d[b];
      #(BIT_NS);
    end
    o_line = 1'b1;
    #(BIT_NS);
  endtask
endmodule

// >>> rs485_uart_port_properties.sv
// Port-level checker for the party-line serial port
`timescale 1ns/10ps
module rs485_uart_port_checker
  import uart485_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [2:0] i_addr,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic i_dir_jumper,
  input wire logic i_rx_line,
  input wire logic o_tx_line,
  input wire logic o_tx_drive_oe_n,
  input wire logic o_rts,
  input wire logic o_irq
);
  // Fastest bit is 1085 clocks; margin for the fractional tick
  localparam int MIN_RUN = 1080;
  logic last_tx;
  logic next_last_tx;
  logic [15:0] run_len;
  logic [15:0] next_run_len;
  always_comb begin
    next_last_tx = o_tx_line;
    next_run_len = run_len + {15'h0000, run_len != 16'hffff};
    if (o_tx_line != last_tx) begin
      next_run_len = 16'h0001;
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      last_tx <= 1'b1;
      run_len <= 16'hffff;
    end else begin
      last_tx <= next_last_tx;
      run_len <= next_run_len;
    end
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // -----------------------------------------------
  // Properties
  // -----------------------------------------------
  property p_oe_follows_rts;
    o_tx_drive_oe_n == !o_rts;
  endproperty
  a_oe_follows_rts: assert property (p_oe_follows_rts)
    else $error("driver enable is not the inverse of rts");
  property p_rts_forced;
    !i_dir_jumper ##1 !i_dir_jumper |-> o_rts;
  endproperty
  a_rts_forced: assert property (p_rts_forced)
    else $error("rts low with direction jumper absent");
  property p_rts_write;
    i_ce && i_wr && i_addr == OFS_LINE_OUT && i_dir_jumper
      ##1 (i_dir_jumper && !i_wr) [*2] |-> o_rts == $past(i_wdata[BIT_RTS], 2);
  endproperty
  a_rts_write: assert property (p_rts_write)
    else $error("rts does not follow line output bit 1");
  property p_gate_closed;
    i_ce && i_wr && i_addr == OFS_LINE_OUT && !i_wdata[BIT_INT_GATE] |=> ##1 !o_irq;
  endproperty
  a_gate_closed: assert property (p_gate_closed)
    else $error("interrupt request while gate bit clear");
  property p_int_code;
    i_ce && i_rd && i_addr == OFS_INT_CODE |=> o_rdata == INT_NONE || o_rdata == INT_RX_DATA;
  endproperty
  a_int_code: assert property (p_int_code)
    else $error("identification code outside 1 and 4");
  property p_irq_code;
    i_ce && i_rd && i_addr == OFS_INT_CODE && o_irq |=> o_rdata == INT_RX_DATA;
  endproperty
  a_irq_code: assert property (p_irq_code)
    else $error("identification not 4 while data waits");
  property p_irq_status;
    i_ce && i_rd && i_addr == OFS_STATUS && o_irq |=> o_rdata[BIT_RX_READY];
  endproperty
  a_irq_status: assert property (p_irq_status)
    else $error("receive ready clear while data waits");
  property p_bit_time;
    o_tx_line != last_tx |-> run_len >= MIN_RUN;
  endproperty
  a_bit_time: assert property (p_bit_time)
    else $error("transmit level shorter than one bit");
  property p_rdata_stands;
    !i_rd |=> $stable(o_rdata);
  endproperty
  a_rdata_stands: assert property (p_rdata_stands)
    else $error("read data changed without a read");
endmodule
bind rs485_uart_port rs485_uart_port_checker rs485_uart_port_checker_i (.i_sys_clk, .i_rst,
  .i_ce, .i_addr, .i_rd, .i_wr, .i_wdata, .o_rdata, .i_dir_jumper, .i_rx_line, .o_tx_line,
  .o_tx_drive_oe_n, .o_rts, .o_irq);

// >>> rs485_uart_port_tb_top.sv
// Self-checking bench for the party-line serial port
`timescale 1ns/10ps
module rs485_uart_port_tb_top;
  import uart485_pkg::*;
  logic i_sys_clk, i_rst, i_ce, i_rd, i_wr, i_dir_jumper, i_rx_line;
  logic o_tx_line, o_tx_drive_oe_n, o_rts, o_irq, far_tail;
  logic [2:0] i_addr;
  logic [7:0] i_wdata, o_rdata, far_byte, far_count, got, base;
  logic [3:0] far_len;
  logic [7:0] rx_vals [5] = '{8'h11, 8'h02, 8'h13, 8'h1c, 8'h07};
  int errors, cmp_count, cnt;
  rs485_uart_port rs485_uart_port_i (.i_sys_clk, .i_rst, .i_ce, .i_addr, .i_rd, .i_wr,
    .i_wdata, .o_rdata, .i_dir_jumper, .i_rx_line, .o_tx_line, .o_tx_drive_oe_n, .o_rts,
    .o_irq);
  remote_station remote_station_i (.i_tx_line(o_tx_line), .i_tx_drive_oe_n(o_tx_drive_oe_n),
    .i_len(far_len), .o_line(i_rx_line), .o_rx_byte(far_byte), .o_rx_count(far_count),
    .o_tail_bit(far_tail));
  initial begin
    i_sys_clk = 1'b0;
    forever #4 i_sys_clk = ~i_sys_clk;
  end
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge i_sys_clk);
    i_addr = a;
    i_wdata = d;
    i_wr = 1'b1;
    @(negedge i_sys_clk);
    i_wr = 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(negedge i_sys_clk);
    i_addr = a;
    i_rd = 1'b1;
    @(negedge i_sys_clk);
    i_rd = 1'b0;
    d = o_rdata;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rdchk(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(d, e);
  endtask
  // Bounded status poll until the given flag reads 1
  task automatic poll(input int b);
    logic [7:0] s;
    s = 8'h00;
    for (int k = 0; k < 8000 && !s[b]; k++) rd(OFS_STATUS, s);
    chk({7'h00, s[b]}, 8'h01);
  endtask
  task automatic put(input logic [7:0] d);
    poll(BIT_THR_EMPTY);
    wr(OFS_DATA, d);
  endtask
  // Stop bits can be a whole frame away, so bounded wait
  task automatic wait_far(input logic [7:0] n);
    for (int k = 0; k < 40000 && far_count !== n; k++) @(negedge i_sys_clk);
    chk(far_count, n);
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #800000;
    errors++;
    close_out();
  end
  // -----------------------------------------------
  // Main sequence
  // -----------------------------------------------
  initial begin
    i_rst = 1'b1;
    i_ce = 1'b1;
    i_rd = 1'b0;
    i_wr = 1'b0;
    i_addr = 3'h0;
    i_wdata = 8'h00;
    i_dir_jumper = 1'b1;
    far_len = 4'h8;
    repeat (4) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    i_rst = 1'b0;
    rdchk(OFS_FRAME, FRAME_RESET);
    rdchk(OFS_LINE_OUT, LINE_OUT_RESET);
    rdchk(OFS_STATUS, 8'h60);
    rdchk(OFS_INT_CODE, INT_NONE);
    rdchk(3'h6, 8'h00);
    chk({7'h00, o_rts}, 8'h00);
    wr(OFS_FRAME, 8'h83);
    wr(OFS_DATA, 8'h01);
    wr(OFS_DIV_HIGH, 8'h5a);
    rdchk(OFS_DATA, 8'h01);
    rdchk(OFS_DIV_HIGH, 8'h5a);
    wr(OFS_DIV_HIGH, 8'h00);
    chk({7'h00, o_tx_line}, 8'h01);
    wr(OFS_FRAME, 8'h03);
    rdchk(OFS_FRAME, 8'h03);
    rdchk(OFS_DIV_HIGH, 8'h00);
    rdchk(OFS_DATA, 8'h00);
    rd(OFS_DATA, got);
    wr(OFS_LINE_OUT, 8'h02);
    chk({6'h00, o_rts, o_tx_drive_oe_n}, 8'h02);
    i_dir_jumper = 1'b0;
    wr(OFS_LINE_OUT, 8'h00);
    chk({7'h00, o_rts}, 8'h01);
    i_dir_jumper = 1'b1;
    @(negedge i_sys_clk);
    chk({7'h00, o_rts}, 8'h00);
    wr(OFS_LINE_OUT, 8'h02);
    far_len = 4'h5;
    wr(OFS_FRAME, 8'h00);
    base = far_count;
    put(8'h0a);
    put(8'h15);
    rd(OFS_STATUS, got);
    chk({7'h00, got[BIT_THR_EMPTY]}, 8'h00);
    wait_far(base + 8'h01);
    chk(far_byte, 8'h0a);
    wait_far(base + 8'h02);
    chk(far_byte, 8'h15);
    chk({7'h00, far_tail}, 8'h01);
    for (int n = 6; n <= 8; n++) begin
      // Format changes only once the stop bits are out
      poll(BIT_TX_IDLE);
      far_len = 4'(n);
      // Seven bits go out with odd parity and two stops
      wr(OFS_FRAME, 8'(n - 5) | ((n == 7) ? 8'h0c : 8'h00));
      base = far_count;
      put(8'ha5);
      wait_far(base + 8'h01);
      chk(far_byte, 8'ha5 & 8'((1 << n) - 1));
      chk({7'h00, far_tail}, (n == 7) ? 8'h00 : 8'h01);
    end
    poll(BIT_TX_IDLE);
    wr(OFS_LINE_OUT, 8'h08);
    wr(OFS_FRAME, 8'h00);
    remote_station_i.send_char(rx_vals[0], 5);
    repeat (40) @(negedge i_sys_clk);
    chk({7'h00, o_irq}, 8'h01);
    rdchk(OFS_INT_CODE, INT_RX_DATA);
    rd(OFS_STATUS, got);
    chk({7'h00, got[BIT_RX_READY]}, 8'h01);
    wr(OFS_LINE_OUT, 8'h04);
    @(negedge i_sys_clk);
    chk({7'h00, o_irq}, 8'h00);
    for (int k = 1; k < 5; k++) remote_station_i.send_char(rx_vals[k], 5);
    repeat (40) @(negedge i_sys_clk);
    rd(OFS_STATUS, got);
    chk({6'h00, got[BIT_OVERRUN], got[BIT_RX_READY]}, 8'h03);
    wr(OFS_LINE_OUT, 8'h08);
    cnt = 0;
    got = 8'h00;
    for (int k = 0; k < 8 && got !== INT_NONE; k++) begin
      rd(OFS_INT_CODE, got);
      if (got === INT_RX_DATA && cnt < 5) begin
        rd(OFS_DATA, base);
        chk(base, rx_vals[cnt]);
        cnt++;
      end
    end
    chk(8'(cnt), 8'h04);
    chk({7'h00, o_irq}, 8'h00);
    rd(OFS_STATUS, got);
    chk({7'h00, got[BIT_RX_READY]}, 8'h00);
    close_out();
  end
endmodule
